// ### design/backup_charge_state_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R01 - Wake-up charges at fixed precondition current
// R02 - Wake-up timer equals SMBus timeout period
// R03 - Wake-up starts when cool, supplied, unprogrammed
// R04 - Wake timeout when cold goes off, no fault
// R05 - Hot code stops charge, goes off
// R06 - Over-range or supply loss goes to reset
// R07 - Nonzero current and voltage enter preconditioning
// R08 - Alarm lockout stops charge, goes off
// R09 - Hold stops charge, timers keep running
// R10 - Calibration go bit enters calibration state
// R11 - Zero value or clear bit goes off
// R12 - Battery writes one pair for preconditioning
// R13 - Bulk above threshold, quarter timer expiry off
// R14 - Bulk needs rewrite every timeout period
// R15 - Off blocks charge, restarts on good values
// R16 - Lead-acid starts bulk, status low, untimed
// R17 - Lead-acid charges only supplied, ideal, unheld
// R18 - Overvoltage pauses switching without fault
// R19 - Lead-acid hot halts charge, sets fault
// R20 - Lead-acid cold halts charge, no fault; over-range means absent
// R21 - Shutdown pin or hold stops charging
// R22 - Host starts calibration by go bit
// R23 - Cutoff sets complete, clears active, charges
// R24 - Reset starts in reset, timers cleared
module backup_charge_state_sequencer
   import bcs_pkg::*;
#(
   parameter longint TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [2:0] thermal_safety_code,
   input wire sense_s sense,
   output logic precondCurrentOn,
   output logic bulkCurrentOn,
   output logic pwmRun,
   output logic calCurrentOn,
   output logic charging_status_out,
   output logic charge_fault_out,
   output logic charge_fault_flag
);

   // ----------------------------------------
   // Bus slave and control registers
   // ----------------------------------------
   chg_state_e state;
   chg_state_e next_state;
   logic [31:0] control;
   logic [15:0] chgVolt;
   logic [15:0] chgCur;
   logic pairWrite;
   logic zeroWrite;
   logic calActive;
   logic calComplete;
   logic alarmInhibited;
   logic [39:0] timer;
   logic wbHit;
   logic wrCtl;
   logic wrVolt;

   assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrCtl = wbHit && wb_we_i && wb_adr_i == ADDR_CONTROL;
   assign wrVolt = wbHit && wb_we_i && wb_adr_i == ADDR_CHGVOLT;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wbHit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wbHit && !wb_we_i) begin
         case (wb_adr_i)
            ADDR_CONTROL: wb_dat_o <= control;
            ADDR_STATUS: wb_dat_o <= {24'h00_0000, 2'h0, state};
            ADDR_CHARGER: wb_dat_o <= {28'h000_0000, alarmInhibited, calComplete,
                                       calActive, charge_fault_flag};
            ADDR_CHGVOLT: wb_dat_o <= 32'h0000_0000;
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // Control: hold, clear, calibration go, calibration reset, alarm, current word.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         control <= CONTROL_RESET;
      end else if (wrCtl && wb_sel_i[0]) begin
         control <= {control[31:8], wb_dat_i[7:0]};
      end else begin
         control[CTL_CLEAR] <= 1'b0;
         control[CTL_CALGO] <= 1'b0;
         control[CTL_CALRST] <= 1'b0;
         control[CTL_ALARM] <= 1'b0;
      end
   end

   // Charging voltage and current values are written together with one access.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         chgVolt <= 16'h0000;
         chgCur <= 16'h0000;
         pairWrite <= 1'b0;
         zeroWrite <= 1'b0;
      end else begin
         pairWrite <= wrVolt && wb_dat_i[15:0] != 16'h0000 && wb_dat_i[31:16] != 16'h0000;
         zeroWrite <= wrVolt && (wb_dat_i[15:0] == 16'h0000 || wb_dat_i[31:16] == 16'h0000);
         if (wrVolt && &wb_sel_i) begin
            chgVolt <= wb_dat_i[15:0];
            chgCur <= wb_dat_i[31:16];
         end else if (state != ST_RESET && next_state == ST_RESET) begin
            chgVolt <= 16'h0000; // [R06]
            chgCur <= 16'h0000;
         end
      end
   end

   // ----------------------------------------
   // Charge state machine
   // ----------------------------------------
   logic coolOk;
   logic supplyGood;
   logic valuesSet;
   logic timerDone;
   logic holdCharge;
   logic [39:0] preLimit;

   assign coolOk = thermal_safety_code == TH_COLD || thermal_safety_code == TH_IDEAL ||
                   thermal_safety_code == TH_UNDER;
   assign supplyGood = sense.supplyOk && sense.aboveUvlo && !sense.shutdownPin;
   assign valuesSet = chgVolt != 16'h0000 && chgCur != 16'h0000;
   assign preLimit = 40'(TIMEOUT_CYCLES / PRE_DIV);
   assign timerDone = (state == ST_PRECOND) ? (timer >= preLimit)
                                             : (timer >= 40'(TIMEOUT_CYCLES));
   assign holdCharge = control[CTL_HOLD] || sense.shutdownPin; // [R09] [R21]

   always_comb begin
      next_state = state;
      case (state)
         ST_RESET: begin
            if (supplyGood && thermal_safety_code != TH_OVER && !sense.leadAcid) begin
               if (control[CTL_CALGO] && !charge_fault_flag) begin
                  next_state = ST_CAL;
               end else if (coolOk && !valuesSet) begin
                  next_state = ST_WAKE; // [R03]
               end else if (coolOk) begin
                  next_state = ST_PRECOND;
               end
            end
         end
         ST_WAKE, ST_PRECOND, ST_BULK: begin
            if (!supplyGood || thermal_safety_code == TH_OVER) begin
               next_state = ST_RESET; // [R06]
            end else if (control[CTL_CALGO]) begin
               next_state = ST_CAL; // [R10]
            end else if (thermal_safety_code == TH_HOT) begin
               next_state = ST_OFF; // [R05]
            end else if (control[CTL_ALARM]) begin
               next_state = ST_OFF; // [R08]
            end else if (zeroWrite || control[CTL_CLEAR]) begin
               next_state = ST_OFF; // [R11]
            end else if (state == ST_WAKE && pairWrite) begin
               next_state = ST_PRECOND; // [R07] [R12]
            end else if (state == ST_PRECOND && sense.aboveBulk) begin
               next_state = ST_BULK; // [R13]
            end else if (timerDone) begin
               next_state = ST_OFF; // [R04] [R13] [R14]
            end
         end
         ST_OFF: begin
            if (thermal_safety_code == TH_OVER || !supplyGood) begin
               next_state = ST_RESET;
            end else if (control[CTL_CALGO]) begin
               next_state = ST_CAL; // [R10]
            end else if (pairWrite && coolOk && !control[CTL_HOLD]) begin
               next_state = ST_PRECOND; // [R15]
            end
         end
         ST_CAL: begin
            if (!supplyGood || thermal_safety_code == TH_OVER) begin
               next_state = ST_RESET;
            end else if (sense.calCutoff) begin
               next_state = ST_WAKE; // [R23]
            end
         end
         default: next_state = ST_RESET;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state <= ST_RESET; // [R24]
      end else begin
         state <= next_state;
      end
   end

   // Timer restarts on every state change and on each pair write in bulk.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         timer <= 40'h00_0000_0000; // [R24]
      end else if (next_state != state || (state == ST_BULK && pairWrite)) begin
         timer <= 40'h00_0000_0000; // [R14]
      end else if (state == ST_WAKE || state == ST_PRECOND || state == ST_BULK) begin
         timer <= timer + 40'h00_0000_0001; // [R02] [R09]
      end
   end

   // ----------------------------------------
   // Calibration and status flags
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         calActive <= 1'b0;
         calComplete <= 1'b0;
      end else begin
         calActive <= next_state == ST_CAL; // [R22]
         if (state == ST_CAL && sense.calCutoff) begin
            calComplete <= 1'b1; // [R23]
         end else if (control[CTL_CALRST] || next_state == ST_CAL && state != ST_CAL) begin
            calComplete <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         alarmInhibited <= 1'b0;
      end else if (control[CTL_ALARM] && (state == ST_WAKE || state == ST_PRECOND ||
                                           state == ST_BULK)) begin
         alarmInhibited <= 1'b1;
      end else if (next_state == ST_RESET || pairWrite) begin
         alarmInhibited <= 1'b0;
      end
   end

   // ----------------------------------------
   // Charge outputs
   // ----------------------------------------
   logic leadActive;
   logic hotFault;

   assign leadActive = sense.leadAcid && supplyGood && thermal_safety_code == TH_IDEAL &&
                       !holdCharge; // [R17] [R20]
   assign hotFault = sense.leadAcid && supplyGood && thermal_safety_code == TH_HOT; // [R19]

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         precondCurrentOn <= 1'b0; // [R24]
         bulkCurrentOn <= 1'b0;
         pwmRun <= 1'b0;
         calCurrentOn <= 1'b0;
      end else begin
         precondCurrentOn <= !sense.leadAcid && !holdCharge &&
                             (next_state == ST_WAKE || next_state == ST_PRECOND); // [R01]
         bulkCurrentOn <= (!sense.leadAcid && !holdCharge && next_state == ST_BULK) ||
                          leadActive; // [R16] [R15]
         pwmRun <= !sense.overVolt; // [R18]
         calCurrentOn <= next_state == ST_CAL;
      end
   end

   // Lead-acid status: low while a cycle runs; hot fault leaves it alone.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         charging_status_out <= 1'b1;
         charge_fault_out <= 1'b1;
         charge_fault_flag <= 1'b0;
      end else begin
         if (leadActive) begin
            charging_status_out <= 1'b0; // [R16]
         end else if (!sense.leadAcid || !supplyGood ||
                      thermal_safety_code == TH_OVER) begin
            charging_status_out <= 1'b1;
         end
         charge_fault_out <= !hotFault; // [R19]
         charge_fault_flag <= hotFault; // [R19] [R04]
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   a_hot_to_off: assert property ( // [R05]
      (state == ST_WAKE || state == ST_PRECOND || state == ST_BULK) && supplyGood &&
      thermal_safety_code == TH_HOT && !control[CTL_CALGO] |=> state == ST_OFF)
      else $error("hot did not stop charge");
   a_supply_reset: assert property ( // [R06]
      state != ST_RESET && !supplyGood |=> state == ST_RESET)
      else $error("supply loss not reset");
   a_reset_wake: assert property ( // [R03]
      state == ST_RESET && supplyGood && coolOk && !sense.leadAcid && !valuesSet &&
      !control[CTL_CALGO] |=> state == ST_WAKE) else $error("wake-up did not start");
   a_wake_fixed: assert property ( // [R01]
      state == ST_WAKE && !$past(holdCharge) && !$past(sense.leadAcid)
      |-> precondCurrentOn && !bulkCurrentOn) else $error("wake current wrong");
   a_wake_expire: assert property ( // [R02] [R04]
      state == ST_WAKE && timerDone && supplyGood && coolOk && !pairWrite &&
      !control[CTL_CALGO] |=> state == ST_OFF && !charge_fault_flag)
      else $error("wake expiry wrong");
   a_wake_pair: assert property ( // [R07]
      state == ST_WAKE && pairWrite && supplyGood &&
      thermal_safety_code != TH_OVER && thermal_safety_code != TH_HOT &&
      !control[CTL_CALGO] && !control[CTL_ALARM] && !control[CTL_CLEAR]
      |=> state == ST_PRECOND) else $error("pair write ignored");
   a_pre_bulk: assert property ( // [R13]
      state == ST_PRECOND && sense.aboveBulk && supplyGood && coolOk && !zeroWrite &&
      !control[CTL_CALGO] && !control[CTL_ALARM] && !control[CTL_CLEAR]
      |=> state == ST_BULK) else $error("bulk not entered");
   a_pre_expire: assert property ( // [R13]
      state == ST_PRECOND && timerDone && !sense.aboveBulk && supplyGood && coolOk &&
      !control[CTL_CALGO] |=> state == ST_OFF) else $error("precondition expiry ignored");
   a_bulk_expire: assert property ( // [R14]
      state == ST_BULK && timerDone && supplyGood && coolOk && !control[CTL_CALGO]
      |=> state == ST_OFF) else $error("bulk expiry ignored");
   a_alarm_off: assert property ( // [R08]
      (state == ST_WAKE || state == ST_PRECOND || state == ST_BULK) && control[CTL_ALARM] &&
      supplyGood && thermal_safety_code != TH_OVER && !control[CTL_CALGO]
      |=> state == ST_OFF && alarmInhibited) else $error("alarm did not stop charge");
   a_clear_off: assert property ( // [R11]
      (state == ST_WAKE || state == ST_PRECOND || state == ST_BULK) && control[CTL_CLEAR] &&
      supplyGood && thermal_safety_code != TH_OVER && !control[CTL_CALGO]
      |=> state == ST_OFF) else $error("clear did not stop charge");
   a_zero_off: assert property ( // [R11]
      (state == ST_PRECOND || state == ST_BULK) && zeroWrite && supplyGood && coolOk &&
      !control[CTL_CALGO] && !control[CTL_ALARM] |=> state == ST_OFF)
      else $error("zero write ignored");
   a_calgo_cal: assert property ( // [R10]
      state == ST_OFF && control[CTL_CALGO] && supplyGood && thermal_safety_code != TH_OVER
      |=> state == ST_CAL) else $error("cal go ignored");
   a_off_nocharge: assert property ( // [R15]
      state == ST_OFF && !$past(sense.leadAcid) |-> !precondCurrentOn && !bulkCurrentOn)
      else $error("charge in off");
   a_off_hold: assert property ( // [R15]
      state == ST_OFF && !pairWrite && supplyGood && thermal_safety_code != TH_OVER &&
      !control[CTL_CALGO] |=> state == ST_OFF) else $error("off left without a write");
   a_off_restart: assert property ( // [R15]
      state == ST_OFF && pairWrite && supplyGood && coolOk && !control[CTL_HOLD] &&
      !control[CTL_CALGO] |=> state == ST_PRECOND) else $error("off did not restart");
   a_hold_stops: assert property ( // [R21]
      holdCharge && !sense.leadAcid |=> !precondCurrentOn && !bulkCurrentOn)
      else $error("hold did not stop");
   a_lead_status: assert property ( // [R16]
      leadActive |=> !charging_status_out && bulkCurrentOn)
      else $error("lead-acid charge not shown");
   a_lead_absent: assert property ( // [R20]
      sense.leadAcid && thermal_safety_code == TH_OVER
      |=> charging_status_out && !bulkCurrentOn) else $error("absent battery still charged");
   a_hot_fault: assert property ( // [R19]
      hotFault |=> charge_fault_flag && !charge_fault_out)
      else $error("lead-acid hot fault missing");
   a_cal_active: assert property ( // [R22]
      state == ST_CAL |-> calActive && calCurrentOn)
      else $error("calibration not shown active");
   a_cal_done: assert property ( // [R23]
      state == ST_CAL && sense.calCutoff && supplyGood && thermal_safety_code != TH_OVER
      |=> calComplete && !calActive && state == ST_WAKE) else $error("cal cutoff flags wrong");
   a_ovp_pause: assert property ( // [R18]
      sense.overVolt |=> !pwmRun) else $error("overvoltage not paused");

   c_wake: cover property (state == ST_RESET ##1 state == ST_WAKE);
   c_bulk: cover property (state == ST_PRECOND ##1 state == ST_BULK);
   c_off: cover property (state == ST_BULK ##1 state == ST_OFF);
   c_cal: cover property (state == ST_CAL ##1 state == ST_WAKE);
   c_lead: cover property (leadActive ##1 !charging_status_out);

endmodule
`default_nettype wire

// ### design/bcs_pkg.sv
package bcs_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int TIMEOUT_SEC = 175;
   localparam longint TIMEOUT_CYC = longint'(TIMEOUT_SEC) * longint'(CLK_HZ);
   localparam int PRE_DIV = 4;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CHARGER = 4'h8;
   localparam logic [3:0] ADDR_CHGVOLT = 4'hc;
   localparam int CTL_HOLD = 0;
   localparam int CTL_CLEAR = 1;
   localparam int CTL_CALGO = 2;
   localparam int CTL_CALRST = 3;
   localparam int CTL_ALARM = 4;
   localparam int CTL_CHGCUR = 5;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

   // ----------------------------------------
   // Thermal codes and modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      TH_UNDER = 3'h0,
      TH_COLD = 3'h1,
      TH_IDEAL = 3'h2,
      TH_HOT = 3'h3,
      TH_OVER = 3'h4
   } thermal_e;

   typedef enum logic [5:0] {
      ST_RESET = 6'h01,
      ST_WAKE = 6'h02,
      ST_PRECOND = 6'h04,
      ST_BULK = 6'h08,
      ST_OFF = 6'h10,
      ST_CAL = 6'h20
   } chg_state_e;

   typedef struct packed {
      logic supplyOk;
      logic aboveUvlo;
      logic shutdownPin;
      logic leadAcid;
      logic aboveBulk;
      logic overVolt;
      logic calCutoff;
   } sense_s;

endpackage

// ### tb/battery_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module battery_host_model
   import bcs_pkg::*;
(
   input wire logic clk_sys,
   output var logic cyc,
   output var logic stb,
   output var logic we,
   output var logic [3:0] adr,
   output var logic [3:0] sel,
   output var logic [31:0] datOut,
   input wire logic [31:0] datIn,
   input wire logic ack
);
   // ----------------------------------------
   // Classic single-cycle bus master.
   // ----------------------------------------
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      sel = 4'h0;
      datOut = 32'h0;
   end

   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      datOut <= d;
      do @(posedge clk_sys); while (ack !== 1'b1);
      q = datIn;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      datOut <= ~d;
   endtask

   // The battery sends one current and voltage pair per write.
   task automatic pair_write(input logic [15:0] cur, input logic [15:0] volt);
      logic [31:0] q;
      xfer(1'b1, ADDR_CHGVOLT, {cur, volt}, q);
   endtask

   // The host starts calibration with the go bit.
   task automatic cal_start();
      logic [31:0] q;
      xfer(1'b1, ADDR_CONTROL, 32'h1 << CTL_CALGO, q);
   endtask
endmodule
`default_nettype wire

// ### tb/backup_charge_state_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module backup_charge_state_sequencer_tb_top
   import bcs_pkg::*;
;
   logic clk_sys, rstn, cyc, stb, we, ack;
   logic [3:0] adr, sel;
   logic [31:0] datW, datR, q;
   logic [2:0] thermal;
   sense_s sns;
   logic precondOn, bulkOn, pwmOn, calOn, statusOut, faultOut, faultFlag;
   int errTotal = 0;
   int checkCount = 0;

   backup_charge_state_sequencer #(.TIMEOUT_CYCLES(400)) DUT (.clk_sys(clk_sys), .rstn(rstn),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .thermal_safety_code(thermal),
      .sense(sns), .precondCurrentOn(precondOn), .bulkCurrentOn(bulkOn), .pwmRun(pwmOn),
      .calCurrentOn(calOn), .charging_status_out(statusOut), .charge_fault_out(faultOut),
      .charge_fault_flag(faultFlag));
   battery_host_model bhm (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
      .sel(sel), .datOut(datW), .datIn(datR), .ack(ack));

   // ----------------------------------------
   // Helpers.
   // ----------------------------------------
   initial clk_sys = 1'b0;
   always #10 clk_sys = ~clk_sys;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checkCount, errTotal);
      if (errTotal == 0 && checkCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checkCount++;
      if (got !== exp) begin
         errTotal++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic ctl(input int bitPos);
      bhm.xfer(1'b1, ADDR_CONTROL, 32'h1 << bitPos, q);
   endtask

   task automatic wait_state(input chg_state_e st, input int n);
      for (int i = 0; i < n; i++) begin
         bhm.xfer(1'b0, ADDR_STATUS, 32'h0, q);
         if (q === 32'(st)) break;
      end
      chk(q, 32'(st), "state");
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // ----------------------------------------
   // Scenarios.
   // ----------------------------------------
   task automatic t_wake();
      bhm.xfer(1'b0, ADDR_STATUS, 32'h0, q);
      chk(q, 32'(ST_RESET), "reset state");
      chk({precondOn, bulkOn, calOn, statusOut, faultOut}, 32'h3, "reset outs");
      sns.supplyOk <= 1'b1;
      sns.aboveUvlo <= 1'b1;
      wait_state(ST_WAKE, 20);
      chk({precondOn, bulkOn}, 32'h2, "wake current");
      ctl(CTL_HOLD);
      cyc_n(3);
      chk(32'(precondOn), 32'h0, "held");
      wait_state(ST_WAKE, 1);
      bhm.xfer(1'b1, ADDR_CONTROL, 32'h0, q);
      cyc_n(3);
      chk(32'(precondOn), 32'h1, "resumed");
      $display("done: wake");
   endtask

   task automatic t_bulk();
      bhm.pair_write(16'h0100, 16'h1000);
      wait_state(ST_PRECOND, 20);
      sns.aboveBulk <= 1'b1;
      wait_state(ST_BULK, 20);
      chk({precondOn, bulkOn}, 32'h1, "bulk current");
      repeat (3) begin
         cyc_n(150);
         bhm.pair_write(16'h0100, 16'h1000);
      end
      wait_state(ST_BULK, 1);
      sns.overVolt <= 1'b1;
      cyc_n(3);
      chk({pwmOn, faultFlag}, 32'h0, "overvolt pause");
      sns.overVolt <= 1'b0;
      cyc_n(3);
      chk(32'(pwmOn), 32'h1, "overvolt resume");
      wait_state(ST_OFF, 200);
      chk({precondOn, bulkOn}, 32'h0, "off blocks");
      $display("done: bulk");
   endtask

   task automatic t_precond();
      sns.aboveBulk <= 1'b0;
      bhm.pair_write(16'h0100, 16'h1000);
      wait_state(ST_PRECOND, 20);
      cyc_n(60);
      wait_state(ST_PRECOND, 1);
      wait_state(ST_OFF, 40);
      for (int k = 0; k < 4; k++) begin
         thermal <= TH_IDEAL;
         bhm.pair_write(16'h0100, 16'h1000);
         wait_state(ST_PRECOND, 20);
         case (k)
            0: thermal <= TH_HOT;
            1: ctl(CTL_CLEAR);
            2: bhm.pair_write(16'h0100, 16'h0000);
            default: ctl(CTL_ALARM);
         endcase
         wait_state(ST_OFF, 20);
      end
      $display("done: precond");
   endtask

   task automatic t_cold();
      sns.supplyOk <= 1'b0;
      wait_state(ST_RESET, 20);
      thermal <= TH_COLD;
      sns.supplyOk <= 1'b1;
      wait_state(ST_WAKE, 20);
      wait_state(ST_OFF, 200);
      bhm.xfer(1'b0, ADDR_CHARGER, 32'h0, q);
      chk(q & 32'h1, 32'h0, "no fault");
      $display("done: cold");
   endtask

   task automatic t_cal();
      thermal <= TH_IDEAL;
      bhm.cal_start();
      wait_state(ST_CAL, 20);
      chk(32'(calOn), 32'h1, "cal current");
      bhm.xfer(1'b0, ADDR_CHARGER, 32'h0, q);
      chk(q & 32'h6, 32'h2, "cal active");
      sns.calCutoff <= 1'b1;
      wait_state(ST_WAKE, 20);
      sns.calCutoff <= 1'b0;
      bhm.xfer(1'b0, ADDR_CHARGER, 32'h0, q);
      chk(q & 32'h6, 32'h4, "cal complete");
      $display("done: cal");
   endtask

   task automatic t_lead();
      sns.supplyOk <= 1'b0;
      wait_state(ST_RESET, 20);
      sns.leadAcid <= 1'b1;
      sns.supplyOk <= 1'b1;
      cyc_n(5);
      chk({statusOut, bulkOn}, 32'h1, "lead start");
      thermal <= TH_HOT;
      cyc_n(5);
      chk({statusOut, faultOut, faultFlag}, 32'h1, "lead hot");
      thermal <= TH_IDEAL;
      cyc_n(5);
      chk({faultOut, faultFlag}, 32'h2, "lead cool");
      thermal <= TH_OVER;
      cyc_n(5);
      chk({statusOut, bulkOn}, 32'h2, "lead absent");
      thermal <= TH_IDEAL;
      cyc_n(5);
      sns.shutdownPin <= 1'b1;
      cyc_n(5);
      chk(32'(bulkOn), 32'h0, "shutdown");
      $display("done: lead");
   endtask

   initial begin
      rstn = 1'b0;
      thermal = TH_IDEAL;
      sns = '0;
      cyc_n(10);
      rstn <= 1'b1;
      t_wake();
      t_bulk();
      t_precond();
      t_cold();
      t_cal();
      t_lead();
      tally_and_finish();
   end

   initial begin
      cyc_n(60000);
      errTotal++;
      $display("unexpected at %0t: watchdog", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire
